// file: snm_slave.sv
`timescale 1ns/1ps
`default_nettype none

module snm_slave #(
  parameter int          ADDR_W   = snm_pkg::ADDR_W,
  parameter int          REC_CYC  = snm_pkg::WAKE_RECOVERY_CYC,
  parameter logic [31:0] IDENT    = 32'h5a_7f_12_34  // Arbitrary value
) (
  // Clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_arst_n,
  // Serial pins from the host
  input  wire logic                i_cs_n,
  input  wire logic                i_sck,
  input  wire logic                i_si,
  input  wire logic                i_wp_n,
  input  wire logic                i_hold_n,
  // Serial output pin
  output logic                     o_so,
  output logic                     o_so_oe,
  // Status
  output logic                     o_asleep,
  output snm_pkg::snm_status_s     o_status
);

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  snm_pkg::snm_pins_s pins_in;     // Raw pins
  snm_pkg::snm_pins_s meta_reg;    // First stage, read only by sync_reg
  snm_pkg::snm_pins_s sync_reg;    // Second stage, safe to use
  logic               sck_prev_reg;
  logic               cs_prev_reg;

  assign pins_in = '{cs_n: i_cs_n, sck: i_sck, si: i_si, wp_n: i_wp_n, hold_n: i_hold_n};

  // Two flops per pin; deselected is the safe reset level
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      meta_reg     <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp_n: 1'b1, hold_n: 1'b1};
      sync_reg     <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp_n: 1'b1, hold_n: 1'b1};
      sck_prev_reg <= 1'b0;
      cs_prev_reg  <= 1'b1;
    end
    else
    begin
      meta_reg     <= pins_in;
      sync_reg     <= meta_reg;
      sck_prev_reg <= sync_reg.sck;
      cs_prev_reg  <= sync_reg.cs_n;
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  snm_pkg::snm_state_e state_reg;     // Command decoder state
  snm_pkg::snm_state_e opc_next;      // State chosen by opcode
  logic [4:0]          cnt_reg;       // Bit counter in current phase
  logic [7:0]          sh_reg;        // Input shift register
  logic [ADDR_W-1:0]   addr_reg;      // Array address
  logic                cmd_wr_reg;    // Address phase belongs to a write
  logic                cmd_fast_reg;  // Address phase belongs to fast read
  logic                wel_reg;       // Write enable latch
  logic [5:0]          nv_reg;        // Status bits 7..2
  logic                so_reg;        // Serial output data
  logic                asleep_reg;    // Sleeping or recovering
  logic                waking_reg;    // Recovery timer running
  logic [$clog2(REC_CYC+1)-1:0] rec_cnt_reg;
  logic [7:0]          mem [0:(1<<ADDR_W)-1];  // The array

  // ----------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------
  wire       sel      = ~sync_reg.cs_n & ~asleep_reg;
  wire       held     = ~sync_reg.cs_n & ~sync_reg.hold_n;
  wire       rise     = sel & ~held & sync_reg.sck & ~sck_prev_reg;
  wire       fall     = sel & ~held & ~sync_reg.sck & sck_prev_reg;
  wire       cs_rise  = sync_reg.cs_n & ~cs_prev_reg;
  wire       cs_fall  = ~sync_reg.cs_n & cs_prev_reg;
  wire [7:0] byte_in  = {sh_reg[6:0], sync_reg.si};
  wire       cnt_byte = (cnt_reg[2:0] == snm_pkg::BYTE_LAST);
  wire       opc_done = rise & (state_reg == snm_pkg::ST_OPC) & (cnt_reg == snm_pkg::OPC_LAST);
  wire       stw_done = rise & (state_reg == snm_pkg::ST_STW) & cnt_byte;
  wire       wake_done = waking_reg & (rec_cnt_reg == ($clog2(REC_CYC+1))'(REC_CYC - 1));
  wire [1:0] bp       = nv_reg[1:0];
  wire [7:0] status_byte = {nv_reg, wel_reg, 1'b0};

  // Protected range from the block protect bits
  wire addr_prot = (bp == snm_pkg::BP_ALL)
                 | ((bp == snm_pkg::BP_HALF) & (addr_reg >= snm_pkg::BLK_HALF))
                 | ((bp == snm_pkg::BP_QTR) & (addr_reg >= snm_pkg::BLK_QTR));
  // Write gating: status by latch, protect enable and pin; array by latch and protect bits
  wire stat_wr_ok = wel_reg & ~(nv_reg[5] & ~sync_reg.wp_n);
  wire mem_we     = rise & (state_reg == snm_pkg::ST_WDATA) & cnt_byte
                  & wel_reg & ~addr_prot;
  wire [7:0] mem_rd = mem[addr_reg];

  // Opcode to next state; unknown codes just idle until deselect
  always_comb
  begin
    unique case (byte_in)
      snm_pkg::OPC_STAT_READ:  opc_next = snm_pkg::ST_STR;
      snm_pkg::OPC_STAT_WRITE: opc_next = snm_pkg::ST_STW;
      snm_pkg::OPC_READ,
      snm_pkg::OPC_WRITE,
      snm_pkg::OPC_FAST_READ:  opc_next = snm_pkg::ST_ADDR;
      snm_pkg::OPC_IDENT:      opc_next = snm_pkg::ST_ID;
      snm_pkg::OPC_SLEEP:      opc_next = snm_pkg::ST_SLPW;
      default:                 opc_next = snm_pkg::ST_IGN;   // Latch commands and illegal codes
    endcase
  end

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  // Deselect always wins: a partial opcode is simply dropped
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state_reg    <= snm_pkg::ST_OPC;
      cnt_reg      <= snm_pkg::CNT_ZERO;
      sh_reg       <= 8'h00;
      addr_reg     <= '0;
      cmd_wr_reg   <= 1'b0;
      cmd_fast_reg <= 1'b0;
    end
    else if (sync_reg.cs_n)
    begin
      state_reg <= snm_pkg::ST_OPC;
      cnt_reg   <= snm_pkg::CNT_ZERO;
    end
    else if (rise)
    begin
      sh_reg <= byte_in;
      unique case (state_reg)
        snm_pkg::ST_OPC:
        begin
          cnt_reg <= opc_done ? snm_pkg::CNT_ZERO : cnt_reg + snm_pkg::CNT_ONE;
          if (opc_done)
          begin
            state_reg    <= opc_next;
            cmd_wr_reg   <= (byte_in == snm_pkg::OPC_WRITE);
            cmd_fast_reg <= (byte_in == snm_pkg::OPC_FAST_READ);
          end
        end
        // Top address bits shift out of the register and are lost
        snm_pkg::ST_ADDR:
        begin
          addr_reg <= {addr_reg[ADDR_W-2:0], sync_reg.si};
          cnt_reg  <= cnt_reg + snm_pkg::CNT_ONE;
          if (cnt_reg == snm_pkg::ADDR_LAST)
          begin
            cnt_reg   <= snm_pkg::CNT_ZERO;
            state_reg <= cmd_wr_reg ? snm_pkg::ST_WDATA :
                         (cmd_fast_reg ? snm_pkg::ST_DUMMY : snm_pkg::ST_RDATA);
          end
        end
        snm_pkg::ST_DUMMY:
        begin
          cnt_reg <= cnt_byte ? snm_pkg::CNT_ZERO : cnt_reg + snm_pkg::CNT_ONE;
          if (cnt_byte)
            state_reg <= snm_pkg::ST_RDATA;
        end
        // Address steps after each byte, wrapping by overflow
        snm_pkg::ST_RDATA,
        snm_pkg::ST_WDATA:
        begin
          cnt_reg <= cnt_byte ? snm_pkg::CNT_ZERO : cnt_reg + snm_pkg::CNT_ONE;
          if (cnt_byte)
            addr_reg <= addr_reg + ADDR_W'(1);
        end
        snm_pkg::ST_STR,
        snm_pkg::ST_STW:
        begin
          cnt_reg <= cnt_byte ? snm_pkg::CNT_ZERO : cnt_reg + snm_pkg::CNT_ONE;
          if (stw_done)
            state_reg <= snm_pkg::ST_IGN;
        end
        snm_pkg::ST_ID:
          cnt_reg <= (cnt_reg == snm_pkg::ID_LAST) ? cnt_reg : cnt_reg + snm_pkg::CNT_ONE;
        snm_pkg::ST_SLPW:
          state_reg <= snm_pkg::ST_IGN;
        snm_pkg::ST_IGN:
          state_reg <= snm_pkg::ST_IGN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Status bits and write enable latch
  // ----------------------------------------------------------------
  // Latch changes only on a recognised opcode or at the end of wake
  // recovery, so an abort in hold before recognition leaves it as it was
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      wel_reg <= 1'b0;
      nv_reg  <= 6'h00;
    end
    else
    begin
      if (wake_done)
        wel_reg <= 1'b0;
      else if (opc_done & (byte_in == snm_pkg::OPC_LATCH_SET))
        wel_reg <= 1'b1;
      else if (opc_done & (byte_in == snm_pkg::OPC_LATCH_CLR))
        wel_reg <= 1'b0;
      // Bits 1 and 0 of the incoming byte are dropped
      if (stw_done & stat_wr_ok)
        nv_reg <= byte_in[7:2];
    end
  end

  // ----------------------------------------------------------------
  // Array write port
  // ----------------------------------------------------------------
  // No reset: contents model nonvolatile storage
  always_ff @(posedge i_clk)
  begin
    if (mem_we)
      mem[addr_reg] <= byte_in;
  end

  // ----------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------
  // Output changes only on falling clock; counters move on rising
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      so_reg <= 1'b0;
    else if (fall)
    begin
      unique case (state_reg)
        snm_pkg::ST_STR:   so_reg <= status_byte[snm_pkg::BYTE_LAST - cnt_reg[2:0]];
        snm_pkg::ST_RDATA: so_reg <= mem_rd[snm_pkg::BYTE_LAST - cnt_reg[2:0]];
        snm_pkg::ST_ID:    so_reg <= IDENT[snm_pkg::ID_LAST - cnt_reg];
        default:           so_reg <= so_reg;
      endcase
    end
  end

  // Drive only while selected, awake, not held, in an output phase
  assign o_so_oe = sel & ~held
                 & ((state_reg == snm_pkg::ST_STR) | (state_reg == snm_pkg::ST_RDATA)
                 | (state_reg == snm_pkg::ST_ID));
  assign o_so    = so_reg;

  // ----------------------------------------------------------------
  // Sleep and wake
  // ----------------------------------------------------------------
  // Entry only if no clock arrived after the opcode (state still waiting)
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      asleep_reg  <= 1'b0;
      waking_reg  <= 1'b0;
      rec_cnt_reg <= '0;
    end
    else if (wake_done)
    begin
      asleep_reg <= 1'b0;
      waking_reg <= 1'b0;
    end
    else if (waking_reg)
      rec_cnt_reg <= rec_cnt_reg + ($clog2(REC_CYC+1))'(1);
    else if (asleep_reg & cs_fall)
    begin
      waking_reg  <= 1'b1;
      rec_cnt_reg <= '0;
    end
    // Held is already low once select is seen high, so test the hold pin itself
    else if (cs_rise & (state_reg == snm_pkg::ST_SLPW) & sync_reg.hold_n)
      asleep_reg <= 1'b1;
  end

  assign o_asleep = asleep_reg;
  assign o_status = status_byte;

endmodule // snm_slave
`default_nettype wire

// file: snm_pkg.sv
`default_nettype none
package snm_pkg;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OPC_LATCH_SET  = 8'h06;
  localparam logic [7:0] OPC_LATCH_CLR  = 8'h04;
  localparam logic [7:0] OPC_STAT_READ  = 8'h05;
  localparam logic [7:0] OPC_STAT_WRITE = 8'h01;
  localparam logic [7:0] OPC_READ       = 8'h03;
  localparam logic [7:0] OPC_WRITE      = 8'h02;
  localparam logic [7:0] OPC_IDENT      = 8'h9f;
  localparam logic [7:0] OPC_FAST_READ  = 8'h0b;
  localparam logic [7:0] OPC_SLEEP      = 8'hb9;

  // ----------------------------------------------------------------
  // Array geometry and block protection
  // ----------------------------------------------------------------
  localparam int          ADDR_W    = 18;
  localparam logic [17:0] BLK_QTR   = 18'h30000;  // Upper quarter start
  localparam logic [17:0] BLK_HALF  = 18'h20000;  // Upper half start
  localparam logic [1:0]  BP_NONE   = 2'h0;
  localparam logic [1:0]  BP_QTR    = 2'h1;
  localparam logic [1:0]  BP_HALF   = 2'h2;
  localparam logic [1:0]  BP_ALL    = 2'h3;

  // ----------------------------------------------------------------
  // Bit counts within a frame
  // ----------------------------------------------------------------
  localparam logic [4:0] CNT_ZERO   = 5'h00;
  localparam logic [4:0] CNT_ONE    = 5'h01;
  localparam logic [4:0] OPC_LAST   = 5'h07;  // 8 opcode bits
  localparam logic [4:0] ADDR_LAST  = 5'h17;  // 24 address bits
  localparam logic [4:0] ID_LAST    = 5'h1f;  // 32 ident bits
  localparam logic [2:0] BYTE_LAST  = 3'h7;

  // ----------------------------------------------------------------
  // Timing: wake recovery, longest time, rounds down
  // ----------------------------------------------------------------
  localparam int WAKE_RECOVERY_TIME_US = 400;
  localparam int CLK_MHZ               = 250;
  localparam int WAKE_RECOVERY_CYC     = WAKE_RECOVERY_TIME_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       status_protect_enable;  // Bit 7
    logic [2:0] spare;                  // Bits 6..4, unused storage
    logic       block_protect_hi;       // Bit 3
    logic       block_protect_lo;       // Bit 2
    logic       write_enable_latch;     // Bit 1
    logic       zero;                   // Bit 0, always 0
  } snm_status_s;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic wp_n;
    logic hold_n;
  } snm_pins_s;

  typedef enum logic [3:0] {
    ST_OPC, ST_ADDR, ST_DUMMY, ST_RDATA, ST_WDATA,
    ST_STW, ST_STR, ST_ID, ST_SLPW, ST_IGN
  } snm_state_e;

endpackage
`default_nettype wire

// file: snm_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module snm_monitor #(
  parameter int REC_CYC = 20  // Wake recovery length in clocks
) (
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_arst_n,
  // Serial pins
  input  wire logic                 i_cs_n,
  input  wire logic                 i_sck,
  input  wire logic                 i_hold_n,
  input  wire logic                 o_so,
  input  wire logic                 o_so_oe,
  // Status
  input  wire logic                 o_asleep,
  input  wire snm_pkg::snm_status_s o_status
);
  // ------------------------------------------------------------
  // Helper history
  // ------------------------------------------------------------
  logic       sck_reg;    // Serial clock one sample back
  logic [5:0] fall_reg;   // Falls seen in the last six samples
  logic [3:0] cs_hi_reg;  // Deselected samples, saturating
  int         asl_reg;    // Asleep cycles since select fell
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // Fall history: output may only move shortly after a fall
  always_ff @(posedge i_clk or negedge i_arst_n)
    if (!i_arst_n)
    begin
      sck_reg  <= 1'b0;
      fall_reg <= 6'h00;
    end
    else
    begin
      sck_reg  <= i_sck;
      fall_reg <= {fall_reg[4:0], sck_reg & ~i_sck};
    end
  // Deselect length and recovery time counters
  always_ff @(posedge i_clk or negedge i_arst_n)
    if (!i_arst_n)
    begin
      cs_hi_reg <= 4'h0;
      asl_reg   <= 0;
    end
    else
    begin
      cs_hi_reg <= !i_cs_n ? 4'h0 : (cs_hi_reg == 4'hf ? cs_hi_reg : cs_hi_reg + 4'h1);
      asl_reg   <= (o_asleep && (asl_reg != 0 || !i_cs_n)) ? asl_reg + 1 : 0;
    end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_cs_float;
    i_cs_n [*5] |-> !o_so_oe;
  endproperty
  a_cs_float: assert property (p_cs_float) else $error("so driven while deselected");
  property p_sleep_float;
    o_asleep |-> !o_so_oe;
  endproperty
  a_sleep_float: assert property (p_sleep_float) else $error("so driven while asleep");
  property p_hold_float;
    (!i_hold_n) [*5] |-> !o_so_oe;
  endproperty
  a_hold_float: assert property (p_hold_float) else $error("so driven during hold");
  property p_so_on_fall;
    o_so_oe && $past(o_so_oe) && $changed(o_so) |-> (|fall_reg);
  endproperty
  a_so_on_fall: assert property (p_so_on_fall) else $error("so moved without a clock fall");
  property p_status_sel;
    $changed(o_status[7:2]) |-> cs_hi_reg < 4'h6;
  endproperty
  a_status_sel: assert property (p_status_sel) else $error("status changed outside a frame");
  property p_sleep_entry;
    $rose(o_asleep) |-> i_cs_n && $past(i_cs_n, 2);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entered while selected");
  property p_wake_bound;
    asl_reg <= REC_CYC + 8;
  endproperty
  a_wake_bound: assert property (p_wake_bound) else $error("wake recovery too long");
  property p_wake_wel;
    $fell(o_asleep) |-> ##[0:1] !o_status.write_enable_latch;
  endproperty
  a_wake_wel: assert property (p_wake_wel) else $error("latch kept over wake");
endmodule // snm_monitor
`default_nettype wire

// file: snm_host.sv
`timescale 1ns/1ps
`default_nettype none
module snm_host (
  // Clock and device output
  input  wire logic i_clk,
  input  wire logic i_so,
  // Pins into the device
  output var logic  o_cs_n,
  output var logic  o_sck,
  output var logic  o_si,
  output var logic  o_wp_n,
  output var logic  o_hold_n
);
  // ------------------------------------------------------------
  // Mode 0 or mode 3 master, serial clock idles low or high between frames
  // ------------------------------------------------------------
  localparam int HALF = 16;  // Half period in clocks, 64 ns with the 4 ns bench clock
  logic sck_idle;            // Clock level between frames: 0 mode 0, 1 mode 3
  initial
  begin
    sck_idle = 1'b0;
    o_cs_n   = 1'b1;
    o_sck    = 1'b0;
    o_si     = 1'b0;
    o_wp_n   = 1'b1;
    o_hold_n = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // Select edges keep a full half period of setup and deselect time
  task automatic frame(input logic sel);
    @(posedge i_clk);
    o_cs_n <= !sel;
    tick(HALF);
  endtask
  // Pin changes leave the serial clock as it is; also used inside a command to take hold
  task automatic set_pins(input logic wp_n, input logic hold_n);
    @(posedge i_clk);
    o_wp_n   <= wp_n;
    o_hold_n <= hold_n;
    tick(HALF);
  endtask
  // Mode change parks the clock at its new idle level; only between frames
  task automatic set_mode(input logic idle);
    @(posedge i_clk);
    sck_idle = idle;
    o_sck    <= idle;
    tick(HALF);
  endtask
  // Bits leave MSB first; input is sampled just before the rise
  task automatic shift(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = 32'h0;
    for (int i = 0; i < n; i++)
    begin
      o_si <= tx[31 - i];
      // Mode 3 falls before each bit, mode 0 after it
      if (sck_idle)
        o_sck <= 1'b0;
      tick(HALF);
      rx = {rx[30:0], i_so};
      o_sck <= 1'b1;
      tick(HALF);
      if (!sck_idle)
        o_sck <= 1'b0;
    end
  endtask
endmodule // snm_host
`default_nettype wire

// file: test_snm_slave.sv
`timescale 1ns/1ps
`default_nettype none
module test_snm_slave;
  // ------------------------------------------------------------
  // Setup
  // ------------------------------------------------------------
  localparam int          REC = 20;             // Short recovery keeps the run brief
  localparam logic [31:0] ID  = 32'hc33c_a596;  // Arbitrary identity value
  logic                 i_clk    = 1'b0;
  logic                 i_arst_n = 1'b0;
  wire logic            cs_n, sck, si, wp_n, hold_n;
  logic                 so, so_oe, asleep;
  logic                 so_last  = 1'b0;        // Last driven output level
  snm_pkg::snm_status_s status;
  logic [31:0]          rx;
  int                   fails    = 0;
  int                   checks   = 0;
  always #2 i_clk = ~i_clk;
  // A released line shows the inverse of its last level
  always @(posedge i_clk) if (so_oe) so_last <= so;
  wire logic so_line = so_oe ? so : ~so_last;
  snm_slave #(.REC_CYC(REC), .IDENT(ID)) u_dut (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_cs_n(cs_n), .i_sck(sck), .i_si(si), .i_wp_n(wp_n),
    .i_hold_n(hold_n), .o_so(so), .o_so_oe(so_oe), .o_asleep(asleep), .o_status(status));
  snm_host u_host (
    .i_clk(i_clk), .i_so(so_line), .o_cs_n(cs_n), .o_sck(sck), .o_si(si), .o_wp_n(wp_n), .o_hold_n(hold_n));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // One framed command: opcode, na address bits, optional hold, nd data bits
  task automatic run(input logic [7:0] op, input logic [23:0] a, input int na, input int nd,
                     input logic [31:0] wd, input logic hold);
    u_host.frame(1'b1);
    u_host.shift(8, {op, 24'h0}, rx);
    u_host.shift(na, {a, 8'h00}, rx);  // Dummy byte follows when na is 32
    if (hold)
    begin
      u_host.set_pins(wp_n, 1'b0);
      check(so_oe, 1'b0);
      u_host.set_pins(wp_n, 1'b1);
    end
    u_host.shift(nd, wd, rx);
    u_host.frame(1'b0);
  endtask
  // Bounded wait on the sleep flag; a timeout ends the run
  task automatic wait_sleep(input logic lvl);
    int n;
    n = 0;
    while (asleep !== lvl && n < REC + 40)
    begin
      @(posedge i_clk);
      n++;
    end
    if (asleep !== lvl)
    begin
      fails++;
      wrap_up();
    end
  endtask
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge i_clk);
    i_arst_n <= 1'b1;
    u_host.tick(4);
    check(status, 8'h00);
    check({so_oe, asleep}, 2'b00);
    u_host.frame(1'b1);
    u_host.shift(7, {snm_pkg::OPC_LATCH_SET, 24'h0}, rx);
    u_host.frame(1'b0);
    check(status, 8'h00);
    run(snm_pkg::OPC_LATCH_SET, 0, 0, 0, 0, 0);
    check(status, 8'h02);
    run(snm_pkg::OPC_WRITE, 24'h02ffff, 24, 16, 32'ha53c_0000, 0);
    check(status, 8'h02);
    run(snm_pkg::OPC_LATCH_CLR, 0, 0, 0, 0, 0);
    check(status, 8'h00);
    run(snm_pkg::OPC_WRITE, 24'h02ffff, 24, 8, 32'hff00_0000, 0);
    run(snm_pkg::OPC_READ, 24'h02ffff, 24, 16, 0, 0);
    check(rx[15:0], 16'ha53c);
    run(snm_pkg::OPC_LATCH_SET, 0, 0, 0, 0, 0);
    run(snm_pkg::OPC_WRITE, 24'h03ffff, 24, 16, 32'h1122_0000, 0);
    run(snm_pkg::OPC_FAST_READ, 24'hffffff, 32, 16, 0, 0);
    check(rx[15:0], 16'h1122);
    run(snm_pkg::OPC_STAT_WRITE, 0, 0, 8, 32'h8f00_0000, 0);
    check(status, 8'h8e);
    run(snm_pkg::OPC_STAT_READ, 0, 0, 16, 0, 0);
    check(rx[15:0], 16'h8e8e);
    u_host.set_pins(1'b0, 1'b1);
    run(snm_pkg::OPC_STAT_WRITE, 0, 0, 8, 32'h0, 0);
    check(status, 8'h8e);
    run(snm_pkg::OPC_WRITE, 24'h02ffff, 24, 8, 32'h7700_0000, 0);
    run(snm_pkg::OPC_READ, 24'h02ffff, 24, 16, 0, 1);
    check(rx[15:0], 16'ha53c);
    u_host.set_pins(1'b1, 1'b1);
    run(snm_pkg::OPC_STAT_WRITE, 0, 0, 8, 32'h8400_0000, 0);
    check(status, 8'h86);
    run(snm_pkg::OPC_WRITE, 24'h02ffff, 24, 16, 32'h5a66_0000, 0);
    run(snm_pkg::OPC_READ, 24'h02ffff, 24, 16, 0, 0);
    check(rx[15:0], 16'h5a3c);
    // Mode 3: clock idles high, hold taken and released with clock high
    u_host.set_mode(1'b1);
    run(snm_pkg::OPC_WRITE, 24'h000000, 24, 8, 32'h9900_0000, 0);
    run(snm_pkg::OPC_READ, 24'h02ffff, 24, 16, 0, 1);
    check(rx[15:0], 16'h5a3c);
    run(snm_pkg::OPC_FAST_READ, 24'h000000, 32, 8, 0, 0);
    check(rx[7:0], 8'h99);
    u_host.set_mode(1'b0);
    // Clocks in hold are ignored, deselect in hold aborts, latch kept
    u_host.frame(1'b1);
    u_host.shift(4, {snm_pkg::OPC_LATCH_CLR, 24'h0}, rx);
    u_host.set_pins(wp_n, 1'b0);
    u_host.shift(4, {snm_pkg::OPC_LATCH_CLR[3:0], 28'h0}, rx);
    u_host.frame(1'b0);
    u_host.set_pins(wp_n, 1'b1);
    check(status, 8'h86);
    run(snm_pkg::OPC_IDENT, 0, 0, 40, 0, 0);
    check(rx, {ID[23:0], {8{ID[0]}}});
    run(snm_pkg::OPC_SLEEP, 0, 0, 1, 0, 0);
    check(asleep, 1'b0);
    run(snm_pkg::OPC_SLEEP, 0, 0, 0, 0, 0);
    wait_sleep(1'b1);
    check(so_oe, 1'b0);
    u_host.frame(1'b1);
    wait_sleep(1'b0);
    u_host.frame(1'b0);
    check(status, 8'h84);
    wrap_up();
  end
endmodule // test_snm_slave
bind snm_slave snm_monitor #(.REC_CYC(REC_CYC)) u_mon (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_cs_n(i_cs_n), .i_sck(i_sck), .i_hold_n(i_hold_n),
  .o_so(o_so), .o_so_oe(o_so_oe), .o_asleep(o_asleep), .o_status(o_status));
`default_nettype wire
